// ### hw/ccx_exec.sv
`timescale 1ns/1ps
module ccx_exec
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  input  wire logic [ccx_pkg::InstrWidth-1:0]  instr,
  input  wire logic                            instrValid,
  input  wire logic [ccx_pkg::DataWidth-1:0]   pcHighLatch,
  input  wire logic                            zeroIn,
  output logic      [ccx_pkg::PcWidth-1:0]     pc,
  output logic      [ccx_pkg::DataWidth-1:0]   workReg,
  output logic                                 zeroFlag,
  output logic                                 flushNext,
  output ccx_pkg::ccx_fwrite_type              fileWrite,
  output logic      [ccx_pkg::DataWidth-1:0]   fileRdData
);
  import ccx_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic ccx_op_type decodeOp(input logic [InstrWidth-1:0] w);
    ccx_op_type op;
    op = OP_NONE;
    if (w[13:11] == OpJump)
    begin
      op = OP_JUMP;
    end
    else if (w[13:8] == OpClearGroup)
    begin
      op = w[DestBit] ? OP_CLEAR_FILE : OP_CLEAR_WORK;
    end
    else if (w[13:8] == OpDecFile)
    begin
      op = OP_DEC_FILE;
    end
    else if (w[13:8] == OpDecSkip)
    begin
      op = OP_DEC_SKIP;
    end
    else if (w[13:8] == OpIncSkip)
    begin
      op = OP_INC_SKIP;
    end
    return op;
  endfunction : decodeOp

  // ----------------------------------------------------------------
  // two-stage pipe: the operand read is registered, so the instruction
  // is held one cycle and executed when its read data arrive
  // ----------------------------------------------------------------
  logic [InstrWidth-1:0] exInstr_q, exInstr_d;
  logic                  exValid_q, exValid_d;
  ccx_state_type         state_q, state_d;
  logic [PcWidth-1:0]    pc_q, pc_d;
  logic [DataWidth-1:0]  work_q, work_d;
  logic                  zero_q, zero_d;
  ccx_op_type            exOp;
  logic [DataWidth-1:0]  opData;
  logic [DataWidth-1:0]  result;
  logic                  exDest;
  ccx_fwrite_type        fw;
  logic                  skip;
  logic                  flush;

  ccx_file_ram #(.Depth(RegCount)) u_ram
  (
    .clk_sys (clk_sys),
    .rdAddr  (instr[AddrWidth-1:0]),
    .rdData  (opData),
    .wrReq   (fw)
  );

  assign exOp   = exValid_q ? decodeOp(exInstr_q) : OP_NONE;
  assign exDest = exInstr_q[DestBit];

  // arithmetic and destination steering
  always_comb
  begin
    result  = opData;
    work_d  = work_q;
    zero_d  = zeroIn ? 1'b1 : zero_q;
    fw      = '{en: 1'b0, addr: exInstr_q[AddrWidth-1:0], data: ZeroData};
    skip    = 1'b0;
    flush   = 1'b0;
    pc_d    = pc_q;
    unique case (exOp)
      OP_CLEAR_FILE:
      begin
        fw.en  = 1'b1;
        zero_d = 1'b1;
      end
      OP_CLEAR_WORK:
      begin
        work_d = ZeroData;
        zero_d = 1'b1;
      end
      OP_DEC_FILE, OP_DEC_SKIP:
      begin
        result = DataWidth'(opData - OneData);
      end
      OP_INC_SKIP:
      begin
        result = DataWidth'(opData + OneData);
      end
      OP_JUMP:
      begin
        pc_d  = {pcHighLatch[LatchHiBit:LatchLoBit],
                 exInstr_q[LitWidth-1:0]};
        flush = 1'b1;
      end
      default:
      begin
        result = opData;
      end
    endcase
    if (exOp == OP_DEC_FILE || exOp == OP_DEC_SKIP || exOp == OP_INC_SKIP)
    begin
      if (exDest)
      begin
        fw.en   = 1'b1;
        fw.data = result;
      end
      else
      begin
        work_d = result;
      end
      if (exOp == OP_DEC_FILE)
      begin
        zero_d = zeroIn || (result == ZeroData);
      end
      else
      begin
        skip  = (result == ZeroData);
        flush = skip;
      end
    end
    if (exOp != OP_JUMP && instrValid && !flush)
    begin
      pc_d = PcWidth'(pc_q + 13'h0001);
    end
  end

  // state and pipe next values; only the word behind a flush is dropped,
  // the bubble cycle itself still takes the word after it
  always_comb
  begin
    state_d   = flush ? ST_FLUSH : ST_RUN;
    exInstr_d = flush ? NopWord : instr;
    exValid_d = instrValid && !flush;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q   <= ST_RUN;
      exInstr_q <= NopWord;
      exValid_q <= 1'b0;
      pc_q      <= PcReset;
      work_q    <= ZeroData;
      zero_q    <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      exInstr_q <= exInstr_d;
      exValid_q <= exValid_d;
      pc_q      <= pc_d;
      work_q    <= work_d;
      zero_q    <= zero_d;
    end
  end

  assign pc         = pc_q;
  assign workReg    = work_q;
  assign zeroFlag   = zero_q;
  assign flushNext  = flush;
  assign fileWrite  = fw;
  assign fileRdData = opData;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_skipTaken;
    (exOp == OP_DEC_SKIP || exOp == OP_INC_SKIP) && result == ZeroData;
  endsequence

  sequence s_bubble;
    !exValid_q ##0 state_q == ST_FLUSH;
  endsequence

  a_clear_file_zero: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_CLEAR_FILE |-> fw.en && fw.data == ZeroData ##1 zero_q)
    else $error("clear-file did not clear and set zero");
  a_clear_work: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_CLEAR_WORK |=> work_q == ZeroData && zero_q)
    else $error("clear-working failed");
  a_dec_zero_upd: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_DEC_FILE && !zeroIn |=> zero_q == ($past(result) == ZeroData))
    else $error("decrement zero flag wrong");
  a_dec_dest_work: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_DEC_FILE && !exDest |=> work_q == $past(opData) - OneData)
    else $error("decrement to working wrong");
  a_skip_keeps_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (exOp == OP_DEC_SKIP || exOp == OP_INC_SKIP) && !zeroIn |=> $stable(zero_q))
    else $error("skip op altered zero flag");
  a_skip_bubble: assert property (@(posedge clk_sys) disable iff (rst)
    s_skipTaken |=> s_bubble)
    else $error("skip did not insert no-operation");
  a_inc_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_INC_SKIP && opData == 8'hFF |-> flush && result == ZeroData)
    else $error("increment wrap did not skip");
  a_jump_target: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_JUMP |=> pc_q == {$past(pcHighLatch[LatchHiBit:LatchLoBit]),
                                 $past(exInstr_q[LitWidth-1:0])})
    else $error("jump target wrong");
  a_zero_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
    zeroIn |=> zero_q)
    else $error("outside zero set was lost");
  a_jump_two_cycle: assert property (@(posedge clk_sys) disable iff (rst)
    exOp == OP_JUMP && !zeroIn |=> s_bubble ##0 $stable(zero_q))
    else $error("jump not two cycles or flags changed");
endmodule : ccx_exec

// ### hw/ccx_file_ram.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// file register array, registered read port
// ------------------------------------------------------------------
module ccx_file_ram
#(
  parameter int Depth = ccx_pkg::RegCount
)
(
  input  wire logic                           clk_sys,
  input  wire logic [ccx_pkg::AddrWidth-1:0]  rdAddr,
  output logic      [ccx_pkg::DataWidth-1:0]  rdData,
  input  wire ccx_pkg::ccx_fwrite_type        wrReq
);
  import ccx_pkg::*;

  logic [DataWidth-1:0] mem [Depth];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge clk_sys)
  begin
    if (wrReq.en)
    begin
      mem[wrReq.addr] <= wrReq.data;
    end
    // write-first: back-to-back ops on one register must see the new value
    if (wrReq.en && wrReq.addr == rdAddr)
    begin
      rdData <= wrReq.data;
    end
    else
    begin
      rdData <= mem[rdAddr];
    end
  end
endmodule : ccx_file_ram

// ### hw/ccx_pkg.sv
package ccx_pkg;
  // ----------------------------------------------------------------
  // widths and field positions of the 14-bit instruction word
  // ----------------------------------------------------------------
  localparam int DataWidth   = 8;
  localparam int AddrWidth   = 7;
  localparam int PcWidth     = 13;
  localparam int LitWidth    = 11;
  localparam int InstrWidth  = 14;
  localparam int DestBit     = 7;
  localparam int LatchLoBit  = 3;
  localparam int LatchHiBit  = 4;
  localparam int RegCount    = 128;

  // ----------------------------------------------------------------
  // opcode patterns, compared against the upper instruction bits
  // ----------------------------------------------------------------
  localparam logic [5:0] OpClearGroup  = 6'h01;
  localparam logic [5:0] OpDecFile     = 6'h03;
  localparam logic [5:0] OpDecSkip     = 6'h0B;
  localparam logic [5:0] OpIncSkip     = 6'h0F;
  localparam logic [2:0] OpJump        = 3'h5;

  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [DataWidth-1:0] ZeroData  = 8'h00;
  localparam logic [DataWidth-1:0] OneData   = 8'h01;
  localparam logic [PcWidth-1:0]   PcReset   = 13'h0000;
  localparam logic [InstrWidth-1:0] NopWord  = 14'h0000;

  // decoded operation class
  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_CLEAR_FILE = 3'h1,
    OP_CLEAR_WORK = 3'h2,
    OP_DEC_FILE   = 3'h3,
    OP_DEC_SKIP   = 3'h4,
    OP_INC_SKIP   = 3'h5,
    OP_JUMP       = 3'h6
  } ccx_op_type;

  // execution phase; gray codes along run -> flush
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_FLUSH = 1'b1
  } ccx_state_type;

  // write request towards the file register array
  typedef struct packed {
    logic                 en;
    logic [AddrWidth-1:0] addr;
    logic [DataWidth-1:0] data;
  } ccx_fwrite_type;

  // status flag update
  typedef struct packed {
    logic en;
    logic value;
  } ccx_zflag_type;
endpackage : ccx_pkg

// ### tb/ccx_fetch_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// fetch side: feeds queued words, one per cycle
// ------------------------------------------------
module ccx_fetch_model
(
  input  wire logic                           clk_sys,
  output logic      [ccx_pkg::InstrWidth-1:0] instr,
  output logic                                instrValid,
  output logic      [ccx_pkg::DataWidth-1:0]  pcHighLatch,
  output logic                                zeroIn
);
  import ccx_pkg::*;
  logic [InstrWidth-1:0] prog[$];

  // idle before the first word
  initial
  begin
    instr = NopWord;
    instrValid = 1'b0;
    pcHighLatch = ZeroData;
    zeroIn = 1'b0;
  end

  // idle word toggles so a stale word never passes for a real one
  always @(negedge clk_sys)
  begin
    instrValid <= (prog.size() > 0);
    instr      <= (prog.size() > 0) ? prog.pop_front() : ~instr;
  end
endmodule : ccx_fetch_model

// ### tb/clear_count_skip_branch_exec_tb.sv
`timescale 1ns/1ps
module clear_count_skip_branch_exec_tb;
  import ccx_pkg::*;
  typedef logic [25:0] ccx_note_type; // rd check, operand, en, addr, data, flush

  logic                  clk_sys = 1'b0;
  logic                  rst = 1'b1;
  logic [InstrWidth-1:0] instr;
  logic                  instrValid;
  logic [DataWidth-1:0]  pcHighLatch;
  logic                  zeroIn;
  logic [PcWidth-1:0]    pc;
  logic [DataWidth-1:0]  workReg;
  logic                  zeroFlag;
  logic                  flushNext;
  ccx_fwrite_type        fileWrite;
  logic [DataWidth-1:0]  fileRdData;
  ccx_note_type          notes[$];
  ccx_note_type          nt;
  int                    error_cnt = 0;
  int                    total_checks = 0;
  int                    seed = 32'hd306;
  logic [AddrWidth-1:0]  a;
  logic [LitWidth-1:0]   k;
  logic [DataWidth-1:0]  lat;

  always #4 clk_sys = ~clk_sys;

  ccx_exec i_dut (.clk_sys(clk_sys), .rst(rst), .instr(instr), .instrValid(instrValid),
    .pcHighLatch(pcHighLatch), .zeroIn(zeroIn), .pc(pc), .workReg(workReg),
    .zeroFlag(zeroFlag), .flushNext(flushNext), .fileWrite(fileWrite),
    .fileRdData(fileRdData));
  ccx_fetch_model i_fetch (.clk_sys(clk_sys), .instr(instr), .instrValid(instrValid),
    .pcHighLatch(pcHighLatch), .zeroIn(zeroIn));

  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    total_checks++;
    if (exp !== got)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // queue a word; a kept word that writes or skips leaves a note
  task automatic op(input logic [5:0] opc, input logic d, input logic [7:0] res,
                    input logic skip, input logic kept);
    i_fetch.prog.push_back({opc, d, a});
    if (kept && (d || skip))
      notes.push_back({opc != OpClearGroup,
                       (opc == OpIncSkip) ? 8'(res - 8'h01) : 8'(res + 8'h01),
                       d, d ? a : 7'h00, d ? res : 8'h00, skip});
  endtask : op

  // bounded wait until the program has run out and settled
  task automatic drain();
    repeat (200)
      if (i_fetch.prog.size() != 0)
        @(negedge clk_sys);
    repeat (3) @(negedge clk_sys);
    chk("pending notes", 17'h0, 17'(notes.size()));
  endtask : drain

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // results matched in issue order, mid-cycle while they stand
  always @(negedge clk_sys)
    if (!rst && (fileWrite.en !== 1'b0 || flushNext !== 1'b0))
    begin
      nt = notes.size() ? notes.pop_front() : '0;
      chk("write or flush", nt[16:0], {fileWrite.en,
          fileWrite.en ? {fileWrite.addr, fileWrite.data} : 15'h0, flushNext});
      if (nt[25])
        chk("fileRdData", {9'h0, nt[24:17]}, {9'h0, fileRdData});
    end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4)
    begin
      a = 7'($random(seed));
      k = 11'($random(seed));
      lat = 8'($random(seed));
      // back-to-back, wrap to zero with skip, skipped word must not act
      op(OpClearGroup, 1'b1, 8'h00, 1'b0, 1'b1);
      op(OpDecFile, 1'b1, 8'hff, 1'b0, 1'b1);
      op(OpIncSkip, 1'b1, 8'h00, 1'b1, 1'b1);
      op(OpClearGroup, 1'b0, 8'h00, 1'b0, 1'b0);
      op(OpDecSkip, 1'b0, 8'hff, 1'b0, 1'b1);
      drain();
      chk("fileWrite.en", 17'h0, {16'h0, fileWrite.en});
      chk("workReg", 17'h0ff, {9'h0, workReg});
      chk("zeroFlag", 17'h0, {16'h0, zeroFlag});
      // clear working, decrement-skip to zero into the file
      op(OpClearGroup, 1'b0, 8'h00, 1'b0, 1'b1);
      op(OpIncSkip, 1'b1, 8'h01, 1'b0, 1'b1);
      op(OpDecSkip, 1'b1, 8'h00, 1'b1, 1'b1);
      op(OpDecFile, 1'b1, 8'hff, 1'b0, 1'b0);
      drain();
      chk("workReg", 17'h0, {9'h0, workReg});
      chk("zeroFlag", 17'h1, {16'h0, zeroFlag});
      // wrap below zero, skip with the result in working
      op(OpDecFile, 1'b1, 8'hff, 1'b0, 1'b1);
      op(OpIncSkip, 1'b0, 8'h00, 1'b1, 1'b1);
      op(OpClearGroup, 1'b1, 8'h00, 1'b0, 1'b0);
      op(OpDecFile, 1'b0, 8'hfe, 1'b0, 1'b1);
      drain();
      chk("workReg", 17'h0fe, {9'h0, workReg});
      chk("zeroFlag", 17'h0, {16'h0, zeroFlag});
      // jump with a random literal and latch; following word discarded
      i_fetch.pcHighLatch = lat;
      i_fetch.prog.push_back({OpJump, k});
      notes.push_back(17'h1);
      op(OpClearGroup, 1'b1, 8'h00, 1'b0, 1'b0);
      drain();
      chk("pc", {4'h0, lat[LatchHiBit:LatchLoBit], k}, {4'h0, pc});
      chk("zeroFlag", 17'h0, {16'h0, zeroFlag});
      // an outside set of the zero flag outranks a nonzero decrement
      i_fetch.zeroIn = 1'b1;
      op(OpDecFile, 1'b1, 8'hfe, 1'b0, 1'b1);
      drain();
      i_fetch.zeroIn = 1'b0;
      chk("zeroFlag", 17'h1, {16'h0, zeroFlag});
    end
    print_verdict();
  end

  // hang guard, far beyond the well under two hundred cycles the run needs
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end
endmodule : clear_count_skip_branch_exec_tb
